// file: design/bldc_defs.svh
`ifndef BLDC_DEFS_SVH
`define BLDC_DEFS_SVH

`define CLK_HZ 40000000
`define PWM_PERIOD_RST 16'h0271
`define DUTY_CEIL_RST 16'h0258
`define DUTY_FLOOR_RST 16'h0000
`define RAMP_RST 16'h0140
`define STALL_RST 16'h04E2
`define STALL_UNIT 32'h0000_7530
`define WAIT_US 1000
`define WAIT_CYCLES (`CLK_HZ / 1000000 * `WAIT_US)
`define SPI_DIV 8'h04
`define SPI_BITS 5'h10
`define CFG_WRITES 3'h6
`define MODE_HIGH 3'h2
`define MODE_LOW 3'h6

`define ADDR_CTRL 12'h000
`define ADDR_PERIOD 12'h004
`define ADDR_CEIL 12'h008
`define ADDR_FLOOR 12'h00C
`define ADDR_RAMP 12'h010
`define ADDR_STALL 12'h014
`define ADDR_CMD 12'h018
`define ADDR_STATUS 12'h01C
`define ADDR_MASK 12'h020
`define ADDR_STATE 12'h024

`define EV_HALL 0
`define EV_STALL 1
`define EV_CFG_DONE 2
`define EV_BITS 3

`endif

// file: design/bldc_pkg.sv
package bldc_pkg;
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } gate_type;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic mosi;
  } spi_out_type;

  typedef enum logic [1:0] {CFG_SEND, CFG_WAIT, CFG_DONE} cfg_state_type;
endpackage : bldc_pkg

// file: design/driver_spi_frame.sv
`timescale 1ns/1ps
`include "bldc_defs.svh"
module driver_spi_frame (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // frame request
  input wire logic start,
  input wire logic [15:0] frame,
  output logic busy,
  output logic done,
  // serial side
  output bldc_pkg::spi_out_type spi
);
  import bldc_pkg::*;

  logic [15:0] shift_ff;
  logic [4:0] bits_ff;
  logic [7:0] div_ff;
  logic busy_ff, sclk_ff, done_ff;
  wire div_end = (div_ff == `SPI_DIV - 8'h01);

  // mode 0: data set on falling, sampled by driver on rising sclk
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_ff <= 16'h0000;
      bits_ff <= 5'h00;
      div_ff <= 8'h00;
      busy_ff <= 1'b0;
      sclk_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (!busy_ff) begin
        if (start) begin
          busy_ff <= 1'b1;
          shift_ff <= frame;
          bits_ff <= 5'h00;
          div_ff <= 8'h00;
        end
      end else begin
        div_ff <= div_end ? 8'h00 : div_ff + 8'h01;
        if (div_end) begin
          sclk_ff <= ~sclk_ff;
          if (sclk_ff) begin
            shift_ff <= {shift_ff[14:0], 1'b0};
            bits_ff <= bits_ff + 5'h01;
            if (bits_ff == `SPI_BITS - 5'h01) begin
              busy_ff <= 1'b0;
              done_ff <= 1'b1;
            end
          end
        end
      end
    end
  end

  assign busy = busy_ff;
  assign done = done_ff;
  assign spi.cs_n = ~busy_ff;
  assign spi.sclk = sclk_ff;
  assign spi.mosi = busy_ff & shift_ff[15];
endmodule : driver_spi_frame

// file: design/bldc_trapezoidal_pwm_control.sv
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "bldc_defs.svh"
module bldc_trapezoidal_pwm_control #(
  // start-up wait after each driver write, in clocks
  parameter int WAIT_LEN = `WAIT_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // axi4-lite write
  input wire logic [11:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // motor pins
  input wire logic HALL_PHASE_A,
  input wire logic HALL_PHASE_B,
  input wire logic HALL_PHASE_C,
  input wire logic DIRECTION,
  output bldc_pkg::gate_type GATE,
  // gate driver spi
  output logic DRIVER_CHIP_SELECT_N,
  output logic DRIVER_SCLK,
  output logic DRIVER_SDI,
  // interrupt
  output logic IRQ
);
  import bldc_pkg::*;

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  logic [15:0] period_ff, ceil_ff, floor_ff, ramp_ff, stall_set_ff;
  logic [15:0] cmd_ff, target_ff, duty_ff;
  logic enable_ff, stalled_ff, dir_ff, dir_taken_ff;
  logic [`EV_BITS-1:0] status_ff, mask_ff, ev;
  cfg_state_type cfg_ff;
  logic [3:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_ok_ff;
  wire [2:0] hall_s = pin_ok_ff[2:0];

  logic [11:0] awaddr_ff, araddr_ff;
  logic aw_ff, w_ff, bvalid_ff, rvalid_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [3:0] wstrb_ff;

  wire aw_take = AWVALID & ~aw_ff & ~bvalid_ff;
  wire w_take = WVALID & ~w_ff & ~bvalid_ff;
  wire wr_go = aw_ff & w_ff & ~bvalid_ff;
  wire ar_take = ARVALID & ~rvalid_ff;
  wire full_word = (wstrb_ff == 4'hF);
  wire wr_ctrl = wr_go & (awaddr_ff == `ADDR_CTRL);
  wire wr_period = wr_go & (awaddr_ff == `ADDR_PERIOD);
  wire wr_ceil = wr_go & (awaddr_ff == `ADDR_CEIL);
  wire wr_floor = wr_go & (awaddr_ff == `ADDR_FLOOR);
  wire wr_ramp = wr_go & (awaddr_ff == `ADDR_RAMP);
  wire wr_stall = wr_go & (awaddr_ff == `ADDR_STALL);
  wire wr_cmd = wr_go & (awaddr_ff == `ADDR_CMD);
  wire wr_mask = wr_go & (awaddr_ff == `ADDR_MASK);
  wire wr_hit = wr_ctrl | wr_period | wr_ceil | wr_floor | wr_ramp
              | wr_stall | wr_cmd | wr_mask;
  wire rd_status = ar_take & (ARADDR == `ADDR_STATUS);

  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    unique case (ARADDR)
      `ADDR_CTRL: rd_mux = {31'h0, enable_ff};
      `ADDR_PERIOD: rd_mux = {16'h0, period_ff};
      `ADDR_CEIL: rd_mux = {16'h0, ceil_ff};
      `ADDR_FLOOR: rd_mux = {16'h0, floor_ff};
      `ADDR_RAMP: rd_mux = {16'h0, ramp_ff};
      `ADDR_STALL: rd_mux = {16'h0, stall_set_ff};
      `ADDR_CMD: rd_mux = {16'h0, cmd_ff};
      `ADDR_STATUS: rd_mux = {29'h0, status_ff};
      `ADDR_MASK: rd_mux = {29'h0, mask_ff};
      `ADDR_STATE: rd_mux = {duty_ff, 8'h0, hall_s, dir_ff,
                             stalled_ff, cfg_ff == CFG_DONE, 2'h0};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'h0;
    end else begin
      if (aw_take) begin
        aw_ff <= 1'b1;
        awaddr_ff <= AWADDR;
      end
      if (w_take) begin
        w_ff <= 1'b1;
        wdata_ff <= WDATA;
        wstrb_ff <= WSTRB;
      end
      if (wr_go) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? 2'h0 : 2'h2;
      end else if (BREADY) begin
        bvalid_ff <= 1'b0;
      end
      if (ar_take) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mux;
        rresp_ff <= rd_ok ? 2'h0 : 2'h2;
      end else if (RREADY) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign AWREADY = ~aw_ff & ~bvalid_ff;
  assign WREADY = ~w_ff & ~bvalid_ff;
  assign BVALID = bvalid_ff;
  assign BRESP = bresp_ff;
  assign ARREADY = ~rvalid_ff;
  assign RVALID = rvalid_ff;
  assign RDATA = rdata_ff;
  assign RRESP = rresp_ff;

  // partial writes are ignored, only full words update settings
  always_ff @(posedge CLK) begin
    if (RST) begin
      enable_ff <= 1'b0;
      period_ff <= `PWM_PERIOD_RST;
      ceil_ff <= `DUTY_CEIL_RST;
      floor_ff <= `DUTY_FLOOR_RST;
      ramp_ff <= `RAMP_RST;
      stall_set_ff <= `STALL_RST;
      cmd_ff <= 16'h0000;
      mask_ff <= {`EV_BITS{1'b0}};
    end else if (full_word) begin
      if (wr_ctrl) enable_ff <= wdata_ff[0];
      if (wr_period) period_ff <= wdata_ff[15:0];
      if (wr_ceil) ceil_ff <= wdata_ff[15:0];
      if (wr_floor) floor_ff <= wdata_ff[15:0];
      if (wr_ramp) ramp_ff <= wdata_ff[15:0];
      if (wr_stall) stall_set_ff <= wdata_ff[15:0];
      if (wr_cmd) cmd_ff <= wdata_ff[15:0];
      if (wr_mask) mask_ff <= wdata_ff[`EV_BITS-1:0];
    end
  end

  // ------------------------------------------------------------
  // interrupts: set wins over read clear
  // ------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) status_ff <= {`EV_BITS{1'b0}};
    else status_ff <= (rd_status ? {`EV_BITS{1'b0}} : status_ff) | ev;
  end
  assign IRQ = |(status_ff & mask_ff);

  // ------------------------------------------------------------
  // pin inputs: three flops, second and third must agree
  // ------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_s1_ff <= 4'h0;
      pin_s2_ff <= 4'h0;
      pin_s3_ff <= 4'h0;
      pin_ok_ff <= 4'h0;
    end else begin
      pin_s1_ff <= {DIRECTION, HALL_PHASE_C, HALL_PHASE_B, HALL_PHASE_A};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      for (int i = 0; i < 4; i++) begin
        if (pin_s2_ff[i] == pin_s3_ff[i]) pin_ok_ff[i] <= pin_s3_ff[i];
      end
    end
  end

  // direction caught once, when start-up driver configuration completes
  always_ff @(posedge CLK) begin
    if (RST) begin
      dir_ff <= 1'b0;
      dir_taken_ff <= 1'b0;
    end else if (!dir_taken_ff && cfg_ff == CFG_DONE) begin
      dir_ff <= pin_ok_ff[3];
      dir_taken_ff <= 1'b1;
    end
  end

  logic [2:0] hall_prev_ff;
  always_ff @(posedge CLK) begin
    if (RST) hall_prev_ff <= 3'h0;
    else hall_prev_ff <= hall_s;
  end
  wire hall_edge = (hall_prev_ff != hall_s);

  // ------------------------------------------------------------
  // pwm timer: up-down, top from compare channel 0
  // ------------------------------------------------------------
  logic [15:0] cnt_ff, top_ff;
  logic down_ff;
  wire at_top = (cnt_ff >= top_ff - 16'h0001);
  wire at_bot = down_ff & (cnt_ff == 16'h0000);
  // period of 2*top-1 cycles: 0 up to top-1, down to 0
  always_ff @(posedge CLK) begin
    if (RST) begin
      cnt_ff <= 16'h0000;
      down_ff <= 1'b0;
      top_ff <= `PWM_PERIOD_RST;
    end else if (at_bot) begin
      cnt_ff <= 16'h0000;
      down_ff <= 1'b0;
      top_ff <= period_ff;
    end else if (!down_ff && at_top) begin
      cnt_ff <= cnt_ff - 16'h0001;
      down_ff <= 1'b1;
    end else begin
      cnt_ff <= down_ff ? cnt_ff - 16'h0001 : cnt_ff + 16'h0001;
    end
  end
  wire period_end = at_bot;

  // ------------------------------------------------------------
  // duty: clamp and ramp
  // ------------------------------------------------------------
  wire [15:0] clamped = (cmd_ff > ceil_ff) ? ceil_ff : cmd_ff;
  wire [15:0] goal = (clamped < floor_ff) ? floor_ff : clamped;
  logic [15:0] ramp_cnt_ff;
  wire ramp_tick = period_end & (ramp_cnt_ff + 16'h0001 >= ramp_ff);
  wire run = enable_ff & ~stalled_ff & (cfg_ff == CFG_DONE);
  always_ff @(posedge CLK) begin
    if (RST) begin
      target_ff <= 16'h0000;
      duty_ff <= `DUTY_FLOOR_RST;
      ramp_cnt_ff <= 16'h0000;
    end else begin
      target_ff <= goal;
      if (period_end) ramp_cnt_ff <= ramp_tick ? 16'h0000
                                               : ramp_cnt_ff + 16'h0001;
      if (duty_ff < floor_ff) duty_ff <= floor_ff;
      else if (ramp_tick && duty_ff < target_ff)
        duty_ff <= duty_ff + 16'h0001;
      else if (ramp_tick && duty_ff > target_ff)
        duty_ff <= duty_ff - 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // blocked rotor timeout
  // ------------------------------------------------------------
  logic [31:0] stall_cnt_ff;
  wire [31:0] stall_lim = 32'(stall_set_ff) * `STALL_UNIT;
  wire stall_hit = run & (duty_ff != 16'h0000) & ~hall_edge
                 & (stall_cnt_ff + 32'h1 >= stall_lim);
  always_ff @(posedge CLK) begin
    if (RST) begin
      stall_cnt_ff <= 32'h0;
      stalled_ff <= 1'b0;
    end else begin
      if (hall_edge || duty_ff == 16'h0000 || !run)
        stall_cnt_ff <= 32'h0;
      else
        stall_cnt_ff <= stall_cnt_ff + 32'h1;
      if (stall_hit) stalled_ff <= 1'b1;
      else if (wr_ctrl && full_word && !wdata_ff[0]) stalled_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // six-step commutation
  // ------------------------------------------------------------
  // mode 2 toggle/reset gives high while count below compare,
  // mode 6 toggle/set is its complement
  wire hs_pwm = (cnt_ff < duty_ff);
  logic [1:0] hi_ph, lo_ph;
  logic step_ok;
  always_comb begin
    step_ok = 1'b1;
    unique case (hall_s ^ {3{dir_ff}})
      3'h1: begin hi_ph = 2'd0; lo_ph = 2'd1; end
      3'h3: begin hi_ph = 2'd0; lo_ph = 2'd2; end
      3'h2: begin hi_ph = 2'd1; lo_ph = 2'd2; end
      3'h6: begin hi_ph = 2'd1; lo_ph = 2'd0; end
      3'h4: begin hi_ph = 2'd2; lo_ph = 2'd0; end
      3'h5: begin hi_ph = 2'd2; lo_ph = 2'd1; end
      default: begin
        hi_ph = 2'd0;
        lo_ph = 2'd0;
        step_ok = 1'b0;
      end
    endcase
  end

  gate_type gate_ff;
  always_ff @(posedge CLK) begin
    if (RST) gate_ff <= '0;
    else if (!run || !step_ok) gate_ff <= '0;
    else begin
      for (int p = 0; p < 3; p++) begin
        gate_ff.high[p] <= (hi_ph == 2'(p)) & hs_pwm;
        gate_ff.low[p] <= ((hi_ph == 2'(p)) & ~hs_pwm) | (lo_ph == 2'(p));
      end
    end
  end
  assign GATE = gate_ff;

  // ------------------------------------------------------------
  // start-up driver configuration
  // ------------------------------------------------------------
  logic [2:0] cfg_idx_ff;
  logic [31:0] wait_ff;
  logic [15:0] cfg_frame;
  logic spi_busy, spi_done, spi_start_ff;
  spi_out_type spi_out;
  always_comb begin
    unique case (cfg_idx_ff)
      3'h0, 3'h1: cfg_frame = {1'b0, 4'h3, 11'h3BF};
      3'h2: cfg_frame = {1'b0, 4'h2, 11'h100};
      3'h3: cfg_frame = {1'b0, 4'h4, 11'h6FF};
      3'h4: cfg_frame = {1'b0, 4'h5, 11'h160};
      default: cfg_frame = {1'b0, 4'h6, 11'h683};
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg_ff <= CFG_SEND;
      cfg_idx_ff <= 3'h0;
      wait_ff <= 32'h0;
      spi_start_ff <= 1'b0;
    end else begin
      spi_start_ff <= 1'b0;
      unique case (cfg_ff)
        CFG_SEND: begin
          if (!spi_busy && !spi_start_ff && !spi_done)
            spi_start_ff <= 1'b1;
          if (spi_done) begin
            cfg_ff <= CFG_WAIT;
            wait_ff <= 32'h0;
          end
        end
        CFG_WAIT: begin
          wait_ff <= wait_ff + 32'h1;
          if (wait_ff + 32'h1 >= 32'(WAIT_LEN)) begin
            if (cfg_idx_ff == `CFG_WRITES - 3'h1) cfg_ff <= CFG_DONE;
            else begin
              cfg_idx_ff <= cfg_idx_ff + 3'h1;
              cfg_ff <= CFG_SEND;
            end
          end
        end
        CFG_DONE: cfg_ff <= CFG_DONE;
      endcase
    end
  end

  driver_spi_frame u_spi (
    .clk(CLK),
    .rst(RST),
    .start(spi_start_ff & ~spi_busy),
    .frame(cfg_frame),
    .busy(spi_busy),
    .done(spi_done),
    .spi(spi_out)
  );
  assign DRIVER_CHIP_SELECT_N = spi_out.cs_n;
  assign DRIVER_SCLK = spi_out.sclk;
  assign DRIVER_SDI = spi_out.mosi;

  // ------------------------------------------------------------
  // events
  // ------------------------------------------------------------
  logic cfg_was_done_ff;
  always_ff @(posedge CLK) begin
    if (RST) cfg_was_done_ff <= 1'b0;
    else cfg_was_done_ff <= (cfg_ff == CFG_DONE);
  end
  always_comb begin
    ev = {`EV_BITS{1'b0}};
    ev[`EV_HALL] = hall_edge;
    ev[`EV_STALL] = stall_hit & ~stalled_ff;
    ev[`EV_CFG_DONE] = (cfg_ff == CFG_DONE) & ~cfg_was_done_ff;
  end
endmodule : bldc_trapezoidal_pwm_control

// file: test/bldc_checker_assertions.sv
`timescale 1ns/1ps
module bldc_checker (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // register bus answers
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [31:0] RDATA,
  // motor and driver pins
  input wire bldc_pkg::gate_type GATE,
  input wire logic DRIVER_CHIP_SELECT_N,
  input wire logic DRIVER_SCLK,
  input wire logic DRIVER_SDI
);
  import bldc_pkg::*;
  // ----------------------------------------
  // sclk rises counted inside one frame
  // ----------------------------------------
  logic [4:0] rise_ff;
  logic sclk_ff;
  always_ff @(posedge CLK) begin
    sclk_ff <= DRIVER_SCLK;
    if (DRIVER_CHIP_SELECT_N) begin
      rise_ff <= 5'h00;
    end else if (DRIVER_SCLK && !sclk_ff) begin
      rise_ff <= rise_ff + 5'h01;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  property p_sclk_idle;
    DRIVER_CHIP_SELECT_N |-> !DRIVER_SCLK;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("sclk moved outside a frame");
  property p_sclk_high;
    $rose(DRIVER_SCLK) |-> DRIVER_SCLK[*4] ##1 !DRIVER_SCLK;
  endproperty
  a_sclk_high: assert property (p_sclk_high)
    else $error("sclk high phase not four cycles");
  property p_sdi_hold;
    DRIVER_SCLK |-> $stable(DRIVER_SDI);
  endproperty
  a_sdi_hold: assert property (p_sdi_hold)
    else $error("sdi changed while sclk high");
  property p_frame_bits;
    $rose(DRIVER_CHIP_SELECT_N) |-> rise_ff == 5'h10;
  endproperty
  a_frame_bits: assert property (p_frame_bits)
    else $error("frame did not carry sixteen bits");
  property p_no_shoot;
    (GATE.high & GATE.low) == 3'h0;
  endproperty
  a_no_shoot: assert property (p_no_shoot)
    else $error("high and low side on together");
  property p_one_high;
    $onehot0(GATE.high);
  endproperty
  a_one_high: assert property (p_one_high)
    else $error("more than one high side on");
  property p_reset_idle;
    disable iff (1'b0) RST |=> GATE == 6'h00 && DRIVER_CHIP_SELECT_N;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs not idle after reset");
  property p_b_hold;
    BVALID && !BREADY |=> BVALID;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_r_hold;
    RVALID && !RREADY |=> RVALID && $stable(RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read answer dropped or changed");
  c_frame: cover property ($rose(DRIVER_CHIP_SELECT_N));
  c_drive: cover property (GATE.high != 3'h0);
  c_write: cover property (BVALID && BREADY);
  c_read: cover property (RVALID && RREADY);
endmodule : bldc_checker

bind bldc_trapezoidal_pwm_control bldc_checker chk_u (
  .CLK(CLK), .RST(RST), .BVALID(BVALID), .BREADY(BREADY),
  .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .GATE(GATE),
  .DRIVER_CHIP_SELECT_N(DRIVER_CHIP_SELECT_N),
  .DRIVER_SCLK(DRIVER_SCLK), .DRIVER_SDI(DRIVER_SDI));

// file: test/gate_driver_model.sv
`timescale 1ns/1ps
module gate_driver_model (
  // configuration port
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi
);
  // ----------------------------------------
  // frame capture
  // ----------------------------------------
  localparam int DEAD_NS = 100;
  logic [15:0] shift;
  logic [15:0] frames [0:7];
  realtime starts [0:7];
  int count = 0;
  int bits = 0;
  int bad = 0;
  always @(negedge cs_n) begin
    bits = 0;
    if (count < 8) starts[count] = $realtime;
  end
  always @(posedge sclk) begin
    if (!cs_n) begin
      shift = {shift[14:0], sdi};
      bits++;
    end
  end
  always @(posedge cs_n) begin
    if (bits == 16 && count < 8) begin
      frames[count] = shift;
      count++;
    end else if (bits != 0) begin
      bad++;
    end
    bits = 0;
  end
endmodule : gate_driver_model

// file: test/bldc_trapezoidal_pwm_control_bench.sv
`timescale 1ns/1ps
`include "bldc_defs.svh"
module bldc_trapezoidal_pwm_control_bench;
  import bldc_pkg::*;
  logic CLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, DIRECTION;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, CS_N, SCLK, SDI;
  logic [11:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rd;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP, rs;
  logic [2:0] hall;
  logic [5:0] prev;
  // short start-up waits keep the run brief
  localparam int WAIT_LEN = 2000;
  localparam real GAP_NS = WAIT_LEN * 25.0;
  gate_type GATE;
  int errors, checks;
  logic [3:0] cfg_addr [6] = '{4'h3, 4'h3, 4'h2, 4'h4, 4'h5, 4'h6};
  logic [10:0] cfg_data [6] = '{11'h3BF, 11'h3BF, 11'h100, 11'h6FF,
                                11'h160, 11'h683};
  logic [2:0] codes [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  bldc_trapezoidal_pwm_control #(.WAIT_LEN(WAIT_LEN)) dut_u (
    .CLK(CLK), .RST(RST),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
    .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .HALL_PHASE_A(hall[0]), .HALL_PHASE_B(hall[1]),
    .HALL_PHASE_C(hall[2]), .DIRECTION(DIRECTION), .GATE(GATE),
    .DRIVER_CHIP_SELECT_N(CS_N), .DRIVER_SCLK(SCLK), .DRIVER_SDI(SDI),
    .IRQ(IRQ));
  gate_driver_model gdrv_u (.cs_n(CS_N), .sclk(SCLK), .sdi(SDI));
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task finish_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task timeout_hit;
    errors++;
    finish_test();
  endtask : timeout_hit
  task wr(input logic [11:0] a, input logic [31:0] d,
          input logic [3:0] s = 4'hF);
    int i;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= s;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      if (BVALID) break;
    end
    if (i == 100) timeout_hit();
    rs = BRESP;
    BREADY <= 1'b0;
  endtask : wr
  task rdr(input logic [11:0] a);
    int i;
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge CLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      if (RVALID) break;
    end
    if (i == 100) timeout_hit();
    rd = RDATA;
    rs = RRESP;
    RREADY <= 1'b0;
  endtask : rdr
  // cycles until the next 0 to nonzero step of the high sides
  task high_edge(output int n);
    for (n = 0; n < 2000 && GATE.high != 3'h0; n++) @(posedge CLK);
    for (; n < 2000 && GATE.high == 3'h0; n++) @(posedge CLK);
    if (n >= 2000) timeout_hit();
  endtask : high_edge
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    logic [11:0] a [5] = '{`ADDR_PERIOD, `ADDR_CEIL, `ADDR_FLOOR,
                           `ADDR_RAMP, `ADDR_STALL};
    logic [31:0] v [5] = '{32'h271, 32'h258, 32'h0, 32'h140, 32'h4E2};
    for (int i = 0; i < 5; i++) begin
      rdr(a[i]);
      check(rd, v[i]);
      check(rs, 2'h0);
    end
    wr(12'h030, 32'h5);
    check(rs, 2'h2);
    rdr(12'h030);
    check(rs, 2'h2);
    check(rd, 32'h0000_0000);
    wr(`ADDR_CEIL, 32'h5, 4'h3);
    check(rs, 2'h0);
    rdr(`ADDR_CEIL);
    check(rd, 32'h258);
  endtask : t_regs
  task t_config;
    int i;
    for (i = 0; i < 400; i++) begin
      repeat (1000) @(posedge CLK);
      rdr(`ADDR_STATE);
      if (rd[2]) break;
    end
    if (i == 400) timeout_hit();
    check(gdrv_u.count, 6);
    check(gdrv_u.bad, 0);
    for (i = 0; i < 6; i++) begin
      check(gdrv_u.frames[i], {1'b0, cfg_addr[i], cfg_data[i]});
    end
    for (i = 0; i < 5; i++) begin
      check(gdrv_u.starts[i + 1] - gdrv_u.starts[i] >= GAP_NS, 1);
    end
    rdr(`ADDR_STATUS);
    check(rd & 32'h4, 32'h4);
    rdr(`ADDR_STATUS);
    check(rd & 32'h4, 32'h0);
    DIRECTION <= 1'b0;
    repeat (8) @(posedge CLK);
    rdr(`ADDR_STATE);
    check(rd[4], 1'b1);
  endtask : t_config
  task t_motor;
    logic [15:0] d1;
    int n;
    hall <= 3'h1;
    wr(`ADDR_PERIOD, 32'h10);
    // let the old, longer period run out
    repeat (1260) @(posedge CLK);
    wr(`ADDR_CEIL, 32'hC);
    wr(`ADDR_FLOOR, 32'h2);
    wr(`ADDR_RAMP, 32'h1);
    wr(`ADDR_STALL, 32'h1);
    wr(`ADDR_MASK, 32'h3);
    wr(`ADDR_CMD, 32'h20);
    wr(`ADDR_CTRL, 32'h1);
    repeat (62) @(posedge CLK);
    rdr(`ADDR_STATE);
    d1 = rd[31:16];
    repeat (124) @(posedge CLK);
    rdr(`ADDR_STATE);
    check(rd[31:16] - d1 inside {16'h3, 16'h4, 16'h5}, 1);
    repeat (620) @(posedge CLK);
    rdr(`ADDR_STATE);
    check(rd[31:16], 32'hC);
    high_edge(n);
    high_edge(n);
    check(n, 31);
    wr(`ADDR_CMD, 32'h0);
    repeat (465) @(posedge CLK);
    rdr(`ADDR_STATE);
    check(rd[31:16], 32'h2);
    wr(`ADDR_CMD, 32'hC);
  endtask : t_motor
  task t_hall;
    int n;
    if (GATE.high == 3'h0) high_edge(n);
    prev = GATE;
    for (int i = 1; i <= 6; i++) begin
      hall <= codes[i % 6];
      repeat (40) @(posedge CLK);
      check(IRQ, 1'b1);
      rdr(`ADDR_STATUS);
      check(rd & 32'h1, 32'h1);
      if (GATE.high == 3'h0) high_edge(n);
      check(GATE !== prev, 1);
      prev = GATE;
    end
    wr(`ADDR_MASK, 32'h2);
    hall <= 3'h3;
    repeat (40) @(posedge CLK);
    check(IRQ, 1'b0);
    rdr(`ADDR_STATUS);
    check(rd & 32'h1, 32'h1);
    wr(`ADDR_MASK, 32'h3);
  endtask : t_hall
  task t_stall;
    repeat (28000) @(posedge CLK);
    rdr(`ADDR_STATE);
    check(rd[3], 1'b0);
    repeat (3000) @(posedge CLK);
    rdr(`ADDR_STATE);
    check(rd[3], 1'b1);
    check(GATE, 6'h00);
    check(IRQ, 1'b1);
    wr(`ADDR_CTRL, 32'h0);
  endtask : t_stall
  initial begin
    errors = 0;
    checks = 0;
    {RST, DIRECTION, hall} = {1'b1, 1'b1, 3'h0};
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    {AWADDR, ARADDR, WDATA, WSTRB} = '0;
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    t_regs();
    t_config();
    t_motor();
    t_hall();
    t_stall();
    finish_test();
  end
endmodule : bldc_trapezoidal_pwm_control_bench
